// ### esr_status.sv
// exposure status report: loop-side and sequencer-side status banks with register port
//
// How it works
// - loop bank refreshes when loop submits values
// - sequencer bank refreshes only when values apply
// - loop bank leads matching sequencer bank values
// - 16-bit counted sample total reported
// - 10-bit average frame level reported
// - loop integration and two amplifier fields reported
// - loop digital multiplier 12-bit unsigned 5.7
// - sequencer step multiplier, 16 bits
// - sequencer array reset length, 16 bits
// - sequencer applied integration, 16 bits
// - sequencer second and third knee values
// - sequencer amplifiers and fine multiplier reported
// - two-knee and three-knee flags reported
// - loop evaluates only every other frame
// - alignment bit defers gain to integration
`timescale 1ns/1ps
module esr_status
(
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	// register port
	input  wire logic [esr_pkg::ADDR_W-1:0]  addr,
	input  wire logic [esr_pkg::DATA_W-1:0]  wr_data,
	input  wire logic                        wr_en,
	input  wire logic                        rd_en,
	output logic      [esr_pkg::DATA_W-1:0]  rd_data,
	// exposure loop
	input  wire logic                        frame_end,
	input  wire logic                        loop_done,
	input  esr_pkg::esr_loop_s               loop_stat,
	output logic                             eval_frame,
	// sequencer
	input  wire logic                        seq_apply,
	input  esr_pkg::esr_seq_s                seq_stat,
	output logic                             req_integ_valid,
	output logic                             req_gain_valid,
	output esr_pkg::esr_req_s                req
);

	// ------------------------------------------------------------
	// read decode
	// ------------------------------------------------------------
	function automatic logic [15:0] read_sel(
		input logic [7:0]          a,
		input esr_pkg::esr_loop_s  lb,
		input esr_pkg::esr_seq_s   sb,
		input logic                al
	);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
			esr_pkg::IDX_SAMPLE_CNT: v = lb.sample_count;
			esr_pkg::IDX_MEAN_LEVEL: v = {6'h00, lb.mean_level};
			esr_pkg::IDX_LOOP_INTEG: v = lb.integration;
			esr_pkg::IDX_LOOP_GAIN:  v = {lb.digital_gain, lb.afe_gain, lb.mux_gain};
			esr_pkg::IDX_GAIN_ALIGN: v[esr_pkg::ALIGN_BIT] = al;
			esr_pkg::IDX_STEP_MULT:  v = sb.step_multiplier;
			esr_pkg::IDX_RESET_SPAN: v = sb.reset_span;
			esr_pkg::IDX_SEQ_INTEG:  v = sb.integration;
			esr_pkg::IDX_KNEE2:      v = sb.second_knee_integration;
			esr_pkg::IDX_KNEE3:      v = sb.third_knee_integration;
			esr_pkg::IDX_SEQ_AMP:    v = {3'h0, sb.amp2, sb.amp1};
			esr_pkg::IDX_SEQ_FINE:   v = {2'h0, sb.three_knee, sb.two_knee,
				sb.applied_fine_multiplier};
			default:                 v = 16'h0000;
		endcase
		return v;
	endfunction

	// indices that answer a read; every other index reads back as zero
	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		case (a)
			esr_pkg::IDX_SAMPLE_CNT,
			esr_pkg::IDX_MEAN_LEVEL,
			esr_pkg::IDX_LOOP_INTEG,
			esr_pkg::IDX_LOOP_GAIN,
			esr_pkg::IDX_GAIN_ALIGN,
			esr_pkg::IDX_STEP_MULT,
			esr_pkg::IDX_RESET_SPAN,
			esr_pkg::IDX_SEQ_INTEG,
			esr_pkg::IDX_KNEE2,
			esr_pkg::IDX_KNEE3,
			esr_pkg::IDX_SEQ_AMP,
			esr_pkg::IDX_SEQ_FINE:   hit = 1'b1;
			default:                 hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	esr_pkg::esr_loop_s   loop_bank_reg;
	esr_pkg::esr_seq_s    seq_bank_reg;
	logic                 align_reg;
	logic [15:0]          rd_data_reg;
	wire logic            loop_acc;
	wire logic            align_wr;
	wire logic [15:0]     rd_mux;
	wire logic [15:0]     rd_next;
	wire logic            addr_hit;

	// ------------------------------------------------------------
	// loop pacing and sequencer requests
	// ------------------------------------------------------------
	esr_req_align u_align
	(
		.mclk            (mclk),
		.sys_rst         (sys_rst),
		.frame_end       (frame_end),
		.loop_done       (loop_done),
		.loop_stat       (loop_stat),
		.align_en        (align_reg),
		.loop_acc        (loop_acc),
		.eval_frame      (eval_frame),
		.req_integ_valid (req_integ_valid),
		.req_gain_valid  (req_gain_valid),
		.req             (req)
	);

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	// the alignment word is the only writable one; all status writes are dropped
	assign align_wr = wr_en & (addr == esr_pkg::IDX_GAIN_ALIGN);
	assign rd_mux   = read_sel(addr, loop_bank_reg, seq_bank_reg, align_reg);
	// data stands for one cycle only, zero otherwise
	assign rd_next  = rd_en ? rd_mux : 16'h0000;
	assign addr_hit = is_mapped(addr);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			align_reg   <= esr_pkg::ALIGN_RST;
			rd_data_reg <= esr_pkg::STATUS_RST;
		end
		else
		begin
			if (align_wr)
				align_reg <= wr_data[esr_pkg::ALIGN_BIT];
			rd_data_reg <= rd_next;
		end
	end

	assign rd_data = rd_data_reg;

	// ------------------------------------------------------------
	// status banks
	// ------------------------------------------------------------
	// whole banks load in one edge, so a read never sees half an update
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			loop_bank_reg <= '0;
			seq_bank_reg  <= '0;
		end
		else
		begin
			if (loop_acc)
				loop_bank_reg <= loop_stat;
			if (seq_apply)
				seq_bank_reg <= seq_stat;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_loop_bank_load: assert property (@(posedge mclk) disable iff (sys_rst)
		loop_acc |=> loop_bank_reg == $past(loop_stat))
		else $error("loop bank missed a submission");

	a_seq_bank_load: assert property (@(posedge mclk) disable iff (sys_rst)
		seq_apply |=> seq_bank_reg == $past(seq_stat))
		else $error("sequencer bank missed an apply");

	a_seq_bank_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!seq_apply |=> $stable(seq_bank_reg))
		else $error("sequencer bank changed without apply");

	a_loop_leads_seq: assert property (@(posedge mclk) disable iff (sys_rst)
		req_integ_valid |-> req.integration == loop_bank_reg.integration)
		else $error("request issued before loop bank shows it");

	a_read_count: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_SAMPLE_CNT)
		|=> rd_data == $past(loop_bank_reg.sample_count))
		else $error("sample count read wrong");

	a_read_mean: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_MEAN_LEVEL)
		|=> rd_data[15:10] == 6'h00 && rd_data[9:0] == $past(loop_bank_reg.mean_level))
		else $error("mean level read wrong");

	a_read_loop_integ: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_LOOP_INTEG)
		|=> rd_data == $past(loop_bank_reg.integration))
		else $error("loop integration read wrong");

	a_read_loop_gain: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_LOOP_GAIN)
		|=> rd_data[15:4] == $past(loop_bank_reg.digital_gain)
		&& rd_data[3:2] == $past(loop_bank_reg.afe_gain)
		&& rd_data[1:0] == $past(loop_bank_reg.mux_gain))
		else $error("loop gain word read wrong");

	a_read_step_mult: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_STEP_MULT)
		|=> rd_data == $past(seq_bank_reg.step_multiplier))
		else $error("step multiplier read wrong");

	a_read_reset_span: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_RESET_SPAN)
		|=> rd_data == $past(seq_bank_reg.reset_span))
		else $error("reset span read wrong");

	a_read_seq_integ: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_SEQ_INTEG)
		|=> rd_data == $past(seq_bank_reg.integration))
		else $error("applied integration read wrong");

	a_read_knee3: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_KNEE3)
		|=> rd_data == $past(seq_bank_reg.third_knee_integration))
		else $error("third knee read wrong");

	a_read_seq_amp: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_SEQ_AMP)
		|=> rd_data[12:5] == $past(seq_bank_reg.amp2)
		&& rd_data[4:0] == $past(seq_bank_reg.amp1)
		&& rd_data[15:13] == 3'h0)
		else $error("applied amplifier word read wrong");

	a_read_knee_flags: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_SEQ_FINE)
		|=> rd_data[esr_pkg::KNEE2_BIT] == $past(seq_bank_reg.two_knee)
		&& rd_data[esr_pkg::KNEE3_BIT] == $past(seq_bank_reg.three_knee))
		else $error("knee flags read wrong");

	a_loop_skip_frame: assert property (@(posedge mclk) disable iff (sys_rst)
		(loop_done && !eval_frame) |=> $stable(loop_bank_reg))
		else $error("loop bank updated on a skipped frame");

	a_status_ro_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_en && !loop_acc) |=> $stable(loop_bank_reg))
		else $error("write disturbed the loop bank");

	a_read_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
		!rd_en |=> rd_data == 16'h0000)
		else $error("read data stood longer than one cycle");

	// ------------------------------------------------------------
	// further read port checks
	// ------------------------------------------------------------
	a_read_knee2: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_KNEE2)
		|=> rd_data == $past(seq_bank_reg.second_knee_integration))
		else $error("second knee read wrong");

	a_read_fine_mult: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_SEQ_FINE)
		|=> rd_data[11:0] == $past(seq_bank_reg.applied_fine_multiplier)
		&& rd_data[15:14] == 2'h0)
		else $error("applied fine multiplier read wrong");

	a_read_align: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && addr == esr_pkg::IDX_GAIN_ALIGN)
		|=> rd_data[esr_pkg::ALIGN_BIT] == $past(align_reg)
		&& rd_data[12:0] == 13'h0 && rd_data[15:14] == 2'h0)
		else $error("alignment word read wrong");

	a_read_unmapped: assert property (@(posedge mclk) disable iff (sys_rst)
		(rd_en && !addr_hit) |=> rd_data == 16'h0000)
		else $error("unmapped index returned data");

	// ------------------------------------------------------------
	// bank and request integrity checks
	// ------------------------------------------------------------
	a_loop_bank_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!loop_acc |=> $stable(loop_bank_reg))
		else $error("loop bank changed without a submission");

	a_integ_request: assert property (@(posedge mclk) disable iff (sys_rst)
		loop_acc |=> req_integ_valid && req.integration == $past(loop_stat.integration))
		else $error("submission did not raise an integration request");

	a_req_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		!loop_acc |=> !req_integ_valid)
		else $error("integration request without a submission");

	a_req_integ_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!loop_acc |=> $stable(req.integration))
		else $error("requested integration moved between submissions");

	a_seq_ro_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(wr_en && !seq_apply) |=> $stable(seq_bank_reg))
		else $error("write disturbed the sequencer bank");

	a_align_write: assert property (@(posedge mclk) disable iff (sys_rst)
		align_wr |=> align_reg == $past(wr_data[esr_pkg::ALIGN_BIT]))
		else $error("alignment bit write lost");

	a_align_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		!align_wr |=> $stable(align_reg))
		else $error("alignment bit changed without a write");

	a_loop_atomic: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(loop_bank_reg) |-> loop_bank_reg == $past(loop_stat))
		else $error("loop bank holds a mix of updates");

	a_seq_atomic: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(seq_bank_reg) |-> seq_bank_reg == $past(seq_stat))
		else $error("sequencer bank holds a mix of updates");

	a_eval_steady: assert property (@(posedge mclk) disable iff (sys_rst)
		!frame_end |=> $stable(eval_frame))
		else $error("evaluation frame flipped without a frame end");

	a_gain_with_integ: assert property (@(posedge mclk) disable iff (sys_rst)
		(loop_acc && !align_reg)
		|=> req_gain_valid && req.digital_gain == $past(loop_stat.digital_gain)
		&& req.afe_gain == $past(loop_stat.afe_gain)
		&& req.mux_gain == $past(loop_stat.mux_gain))
		else $error("unaligned gain did not travel with integration");

	a_gain_idle: assert property (@(posedge mclk) disable iff (sys_rst)
		(!loop_acc && !frame_end) |=> !req_gain_valid)
		else $error("gain request without a cause");

	a_gain_fields_hold: assert property (@(posedge mclk) disable iff (sys_rst)
		(!loop_acc && !frame_end)
		|=> $stable(req.mux_gain) && $stable(req.afe_gain) && $stable(req.digital_gain))
		else $error("requested gain moved without a cause");

endmodule // esr_status

// ### esr_pkg.sv
// shared constants and carriers of the exposure status report block
package esr_pkg;

	// ------------------------------------------------------------
	// register indices (port address is the index itself)
	// ------------------------------------------------------------
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 16;
	localparam logic [7:0]  IDX_SAMPLE_CNT  = 8'hB8;
	localparam logic [7:0]  IDX_MEAN_LEVEL  = 8'hBA;
	localparam logic [7:0]  IDX_LOOP_INTEG  = 8'hBB;
	localparam logic [7:0]  IDX_LOOP_GAIN   = 8'hBC;
	localparam logic [7:0]  IDX_GAIN_ALIGN  = 8'hCC;
	localparam logic [7:0]  IDX_STEP_MULT   = 8'hD0;
	localparam logic [7:0]  IDX_RESET_SPAN  = 8'hD1;
	localparam logic [7:0]  IDX_SEQ_INTEG   = 8'hD2;
	localparam logic [7:0]  IDX_KNEE2       = 8'hD3;
	localparam logic [7:0]  IDX_KNEE3       = 8'hD4;
	localparam logic [7:0]  IDX_SEQ_AMP     = 8'hD5;
	localparam logic [7:0]  IDX_SEQ_FINE    = 8'hD6;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int          ALIGN_BIT       = 13;
	localparam int          KNEE2_BIT       = 12;
	localparam int          KNEE3_BIT       = 13;
	localparam logic [15:0] STATUS_RST      = 16'h0000;
	localparam logic        ALIGN_RST       = 1'b0;
	localparam logic        EVAL_RST        = 1'b1;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] sample_count;
		logic [9:0]  mean_level;
		logic [15:0] integration;
		logic [1:0]  mux_gain;
		logic [1:0]  afe_gain;
		logic [11:0] digital_gain;
	} esr_loop_s;

	typedef struct packed {
		logic [15:0] integration;
		logic [1:0]  mux_gain;
		logic [1:0]  afe_gain;
		logic [11:0] digital_gain;
	} esr_req_s;

	typedef struct packed {
		logic [15:0] step_multiplier;
		logic [15:0] reset_span;
		logic [15:0] integration;
		logic [15:0] second_knee_integration;
		logic [15:0] third_knee_integration;
		logic [4:0]  amp1;
		logic [7:0]  amp2;
		logic [11:0] applied_fine_multiplier;
		logic        two_knee;
		logic        three_knee;
	} esr_seq_s;

endpackage

// ### esr_req_align.sv
// frame pacing of the exposure loop and gain-to-integration alignment of its requests
`timescale 1ns/1ps
module esr_req_align
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// loop side
	input  wire logic              frame_end,
	input  wire logic              loop_done,
	input  esr_pkg::esr_loop_s     loop_stat,
	input  wire logic              align_en,
	output logic                   loop_acc,
	output logic                   eval_frame,
	// sequencer request
	output logic                   req_integ_valid,
	output logic                   req_gain_valid,
	output esr_pkg::esr_req_s      req
);
	logic               eval_reg;
	logic               pend_reg;
	logic [15:0]        pend_gain_reg;
	logic               integ_v_reg;
	logic               gain_v_reg;
	esr_pkg::esr_req_s  req_reg;
	wire logic          gain_now;
	wire logic          gain_late;
	wire logic [15:0]   new_gain;

	// only every other frame is evaluated
	assign loop_acc   = loop_done & eval_reg;
	assign gain_now   = loop_acc & ~align_en;
	assign gain_late  = frame_end & pend_reg;
	assign new_gain   = {loop_stat.mux_gain, loop_stat.afe_gain, loop_stat.digital_gain};

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			eval_reg      <= esr_pkg::EVAL_RST;
			pend_reg      <= 1'b0;
			pend_gain_reg <= esr_pkg::STATUS_RST;
			integ_v_reg   <= 1'b0;
			gain_v_reg    <= 1'b0;
			req_reg       <= '0;
		end
		else
		begin
			if (frame_end)
				eval_reg <= ~eval_reg;
			// with a release and a new deferred set in the same cycle, the old set goes out and the new one stays pending
			pend_reg    <= (loop_acc & align_en) | (pend_reg & ~frame_end);
			if (loop_acc & align_en)
				pend_gain_reg <= new_gain;
			integ_v_reg <= loop_acc;
			gain_v_reg  <= gain_now | gain_late;
			if (loop_acc)
				req_reg.integration <= loop_stat.integration;
			if (gain_now)
				{req_reg.mux_gain, req_reg.afe_gain, req_reg.digital_gain} <= new_gain;
			else if (gain_late)
				{req_reg.mux_gain, req_reg.afe_gain, req_reg.digital_gain} <= pend_gain_reg;
		end
	end

	assign eval_frame      = eval_reg;
	assign req_integ_valid = integ_v_reg;
	assign req_gain_valid  = gain_v_reg;
	assign req             = req_reg;

	a_eval_alternates: assert property (@(posedge mclk) disable iff (sys_rst)
		frame_end |=> eval_reg != $past(eval_reg))
		else $error("evaluation frame did not alternate");
	a_gain_deferred: assert property (@(posedge mclk) disable iff (sys_rst)
		(loop_acc && align_en && !gain_late) |=> !gain_v_reg && pend_reg)
		else $error("aligned gain was not held back");

endmodule // esr_req_align

// ### esr_status_bench.sv
// self-checking testbench of the exposure status report block
`timescale 1ns/1ps
module esr_status_bench;

	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	logic                       mclk            = 1'b0;
	logic                       sys_rst         = 1'b1;
	logic [7:0]                 addr            = 8'h00;
	logic [15:0]                wr_data         = 16'h0000;
	logic                       wr_en           = 1'b0;
	logic                       rd_en           = 1'b0;
	logic [15:0]                rd_data;
	logic                       frame_end       = 1'b0;
	logic                       loop_done       = 1'b0;
	esr_pkg::esr_loop_s         loop_stat       = '0;
	logic                       eval_frame;
	logic                       seq_apply       = 1'b0;
	esr_pkg::esr_seq_s          seq_stat        = '0;
	logic                       req_integ_valid;
	logic                       req_gain_valid;
	esr_pkg::esr_req_s          req;
	esr_pkg::esr_loop_s         l1;
	esr_pkg::esr_loop_s         l2;
	esr_pkg::esr_seq_s          s1;
	int                         bad_count       = 0;
	int                         tests_run       = 0;

	always #2.5 mclk = ~mclk;

	esr_status uut
	(
		.mclk            (mclk),
		.sys_rst         (sys_rst),
		.addr            (addr),
		.wr_data         (wr_data),
		.wr_en           (wr_en),
		.rd_en           (rd_en),
		.rd_data         (rd_data),
		.frame_end       (frame_end),
		.loop_done       (loop_done),
		.loop_stat       (loop_stat),
		.eval_frame      (eval_frame),
		.seq_apply       (seq_apply),
		.seq_stat        (seq_stat),
		.req_integ_valid (req_integ_valid),
		.req_gain_valid  (req_gain_valid),
		.req             (req)
	);

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp, $sformatf("read %h", a));
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge mclk);
		wr_en   <= 1'b0;
	endtask

	task automatic lpulse(input esr_pkg::esr_loop_s s);
		@(posedge mclk);
		loop_stat <= s;
		loop_done <= 1'b1;
		@(posedge mclk);
		loop_done <= 1'b0;
		#1;
	endtask

	task automatic spulse(input esr_pkg::esr_seq_s s);
		@(posedge mclk);
		seq_stat  <= s;
		seq_apply <= 1'b1;
		@(posedge mclk);
		seq_apply <= 1'b0;
	endtask

	task automatic fend();
		@(posedge mclk);
		frame_end <= 1'b1;
		@(posedge mclk);
		frame_end <= 1'b0;
		#1;
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchdog: the sequence needs well under 200 cycles
	// ------------------------------------------------------------
	initial
	begin
		#20000;
		bad_count++;
		final_report();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		l1 = '{16'hA5C3, 10'h2F1, 16'h1234, 2'h1, 2'h3, 12'h8A5};
		l2 = '{16'h0F0F, 10'h155, 16'hBEEF, 2'h0, 2'h2, 12'h1C7};
		s1 = '{16'h0C35, 16'h01F4, 16'h4321, 16'h2222, 16'h1111, 5'h15, 8'hA7, 12'h3C9, 1'b1, 1'b0};
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		chk({15'h0, eval_frame}, 16'h0001, "eval after reset");
		rd(8'hB8, 16'h0000);
		rd(8'hBC, 16'h0000);
		rd(8'hD6, 16'h0000);
		rd(8'h00, 16'h0000);
		// accepted loop result, gains travel with integration
		lpulse(l1);
		chk({15'h0, req_integ_valid}, 16'h0001, "integ request");
		chk({15'h0, req_gain_valid}, 16'h0001, "gain with integ");
		chk(req.integration, l1.integration, "request integ");
		chk({req.digital_gain, req.afe_gain, req.mux_gain},
			{l1.digital_gain, l1.afe_gain, l1.mux_gain}, "gain with integ fields");
		@(posedge mclk);
		#1;
		chk({14'h0, req_integ_valid, req_gain_valid}, 16'h0000, "request pulses end");
		rd(8'hB8, l1.sample_count);
		rd(8'hB9, 16'h0000);
		rd(8'hBA, {6'h00, l1.mean_level});
		rd(8'hBB, l1.integration);
		rd(8'hBC, {l1.digital_gain, l1.afe_gain, l1.mux_gain});
		rd(8'hD2, 16'h0000);
		// status writes must not land
		wr(8'hB8, 16'hFFFF);
		wr(8'hD2, 16'hFFFF);
		rd(8'hB8, l1.sample_count);
		rd(8'hD2, 16'h0000);
		// off frame: loop result dropped
		fend();
		chk({15'h0, eval_frame}, 16'h0000, "eval off frame");
		lpulse(l2);
		chk({15'h0, req_integ_valid}, 16'h0000, "dropped request");
		rd(8'hBB, l1.integration);
		// aligned gains wait for the next frame boundary
		wr(8'hCC, 16'hFFFF);
		rd(8'hCC, 16'h2000);
		fend();
		chk({15'h0, eval_frame}, 16'h0001, "eval on frame");
		lpulse(l2);
		chk({15'h0, req_integ_valid}, 16'h0001, "aligned integ");
		chk({15'h0, req_gain_valid}, 16'h0000, "gain held back");
		rd(8'hBC, {l2.digital_gain, l2.afe_gain, l2.mux_gain});
		fend();
		chk({15'h0, req_gain_valid}, 16'h0001, "gain after frame");
		chk({req.digital_gain, req.afe_gain, req.mux_gain},
			{l2.digital_gain, l2.afe_gain, l2.mux_gain}, "gain fields");
		// sequencer bank follows only the apply pulse
		rd(8'hD0, 16'h0000);
		spulse(s1);
		rd(8'hD0, s1.step_multiplier);
		rd(8'hD1, s1.reset_span);
		rd(8'hD2, s1.integration);
		rd(8'hD3, s1.second_knee_integration);
		rd(8'hD4, s1.third_knee_integration);
		rd(8'hD5, {3'h0, s1.amp2, s1.amp1});
		rd(8'hD6, {2'h0, s1.three_knee, s1.two_knee, s1.applied_fine_multiplier});
		rd(8'hBB, l2.integration);
		s1.two_knee = 1'b0;
		s1.three_knee = 1'b1;
		spulse(s1);
		rd(8'hD6, {2'h0, s1.three_knee, s1.two_knee, s1.applied_fine_multiplier});
		@(posedge mclk);
		#1;
		chk(rd_data, 16'h0000, "idle read data");
		// mid-run reset clears both banks, the alignment bit and the pacing
		@(posedge mclk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		chk({15'h0, eval_frame}, 16'h0001, "eval after second reset");
		chk({14'h0, req_integ_valid, req_gain_valid}, 16'h0000, "requests after reset");
		rd(8'hCC, 16'h0000);
		rd(8'hBB, 16'h0000);
		rd(8'hD6, 16'h0000);
		final_report();
	end

endmodule // esr_status_bench
